// file: verilog/rss_pkg.sv
// Package for the rotate/subtract/sleep execution datapath.
// Assumes a single core clock and a decoder that presents one instruction per cycle.
package rss_pkg;

	// Operand widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int FILE_DEPTH = 128;

	// Reset values and the watchdog timeout
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] FILE_RESET = 8'h00;
	localparam logic [7:0] WDT_CLEARED = 8'h00;
	localparam logic [7:0] PRESCALE_CLEARED = 8'h00;
	localparam logic [15:0] WDT_TIMEOUT = 16'hffff;

	// Destination select encodings
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// Instruction codes from the decoder
	typedef enum logic [2:0] {
		RSS_NOP,
		RSS_ROTATE_RIGHT,
		RSS_LIT_MINUS_ACC,
		RSS_REG_MINUS_ACC,
		RSS_REG_MINUS_ACC_BORROW,
		RSS_SLEEP
	} rss_op_type;

	// Decoded instruction fields
	typedef struct packed {
		rss_op_type        op;
		logic [ADDR_W-1:0] addr;
		logic              dest;
		logic [DATA_W-1:0] literal;
	} rss_instr_type;

	// Status bits
	typedef struct packed {
		logic carry;
		logic half_carry_flag;
		logic zero;
		logic power_down_flag;
		logic watchdog_expiry_flag;
	} rss_status_type;

	localparam rss_status_type STATUS_RESET = '{carry: 1'b0, half_carry_flag: 1'b0, zero: 1'b0,
		power_down_flag: 1'b1, watchdog_expiry_flag: 1'b1};

endpackage

// file: verilog/rss_file_mem.sv
// File register memory for the execution datapath.
// Assumes one read and one write port, read data registered.
`timescale 1ns/100ps
module rss_file_mem (
	// Clock and control
	input  wire logic                     clk_in,
	input  wire logic                     en_in,
	// Read port
	input  wire logic [rss_pkg::ADDR_W-1:0] rd_addr_in,
	output logic      [rss_pkg::DATA_W-1:0] rd_data_out,
	// Write port
	input  wire logic                     wr_en_in,
	input  wire logic [rss_pkg::ADDR_W-1:0] wr_addr_in,
	input  wire logic [rss_pkg::DATA_W-1:0] wr_data_in
);
	// Known power-up contents, so no file register ever starts out unknown
	logic [rss_pkg::DATA_W-1:0] mem_q [rss_pkg::FILE_DEPTH] = '{default: rss_pkg::FILE_RESET};

	// Write-first so a back-to-back read sees fresh data
	always_ff @(posedge clk_in) begin
		if (en_in && wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
	end

	// Registered read with bypass of same-cycle write
	always_ff @(posedge clk_in) begin
		if (en_in) begin
			if (wr_en_in && wr_addr_in == rd_addr_in) begin
				rd_data_out <= wr_data_in;
			end else begin
				rd_data_out <= mem_q[rd_addr_in];
			end
		end
	end
endmodule // rss_file_mem

// file: verilog/rss_exec.sv
// Execution datapath: rotate right, the three subtractions, and sleep.
// Assumes the decoder holds each instruction one cycle; file registers are internal.
`timescale 1ns/100ps
module rss_exec (
	// Clock, reset, enable
	input  wire logic                      ref_clk_in,
	input  wire logic                      reset_in,
	input  wire logic                      clk_en_in,
	// Decoded instruction
	input  wire logic                      instr_valid_in,
	input  wire rss_pkg::rss_instr_type    instr_in,
	// Wake from sleep (pin, synchronised)
	input  wire logic                      wake_in,
	// Watchdog tick from the low-power oscillator domain logic
	input  wire logic                      wdt_tick_in,
	// Results
	output logic [rss_pkg::DATA_W-1:0]     acc_out,
	output rss_pkg::rss_status_type        status_out,
	output logic [rss_pkg::DATA_W-1:0]     wdt_count_out,
	output logic [rss_pkg::DATA_W-1:0]     prescale_out,
	output logic                           sleeping_out,
	output logic                           osc_run_out,
	output logic                           busy_out,
	output logic                           done_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SLEEP} rss_state_type;

	rss_state_type              state_q;
	rss_pkg::rss_instr_type     ins_q;
	logic [rss_pkg::DATA_W-1:0] acc_q;
	rss_pkg::rss_status_type    stat_q;
	logic [rss_pkg::DATA_W-1:0] wdt_q;
	logic [rss_pkg::DATA_W-1:0] pre_q;
	logic                       done_q;
	logic                       wake_s1_q;
	logic                       wake_s2_q;
	logic [rss_pkg::DATA_W-1:0] file_rd;
	logic                       wr_en;
	logic [rss_pkg::DATA_W-1:0] result;
	logic                       c_new;
	logic                       dc_new;
	logic                       is_sub;

	// Subtract with carry-in: carry out means no borrow
	function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b, input logic cin);
		sub9 = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
	endfunction

	// Low-nibble no-borrow flag
	function automatic logic nib_ok(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [4:0] s;
		s = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
		nib_ok = s[4];
	endfunction

	// Fetch operand one cycle ahead of execute
	rss_file_mem u_mem (
		.clk_in      (ref_clk_in),
		.en_in       (clk_en_in),
		.rd_addr_in  (instr_in.addr),
		.rd_data_out (file_rd),
		.wr_en_in    (wr_en),
		.wr_addr_in  (ins_q.addr),
		.wr_data_in  (result)
	);

	// Wake pin synchroniser
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
		end else if (clk_en_in) begin
			wake_s1_q <= wake_in;
			wake_s2_q <= wake_s1_q;
		end
	end

	// Result and flag arithmetic
	always_comb begin
		logic [8:0] d9;
		d9 = 9'h000;
		result = file_rd;
		c_new = stat_q.carry;
		dc_new = stat_q.half_carry_flag;
		is_sub = 1'b0;
		case (ins_q.op)
			rss_pkg::RSS_ROTATE_RIGHT: begin
				result = {stat_q.carry, file_rd[7:1]};
				c_new = file_rd[0];
			end
			rss_pkg::RSS_LIT_MINUS_ACC: begin
				d9 = sub9(ins_q.literal, acc_q, 1'b1);
				result = d9[7:0];
				c_new = d9[8];
				dc_new = nib_ok(ins_q.literal, acc_q, 1'b1);
				is_sub = 1'b1;
			end
			rss_pkg::RSS_REG_MINUS_ACC: begin
				d9 = sub9(file_rd, acc_q, 1'b1);
				result = d9[7:0];
				c_new = d9[8];
				dc_new = nib_ok(file_rd, acc_q, 1'b1);
				is_sub = 1'b1;
			end
			rss_pkg::RSS_REG_MINUS_ACC_BORROW: begin
				d9 = sub9(file_rd, acc_q, stat_q.carry);
				result = d9[7:0];
				c_new = d9[8];
				dc_new = nib_ok(file_rd, acc_q, stat_q.carry);
				is_sub = 1'b1;
			end
			default: begin
				result = file_rd;
			end
		endcase
	end

	// file write only for register ops with dest 1
	assign wr_en = (state_q == ST_EXEC) && (ins_q.dest == rss_pkg::DEST_FILE)
		&& (ins_q.op inside {rss_pkg::RSS_ROTATE_RIGHT, rss_pkg::RSS_REG_MINUS_ACC,
		rss_pkg::RSS_REG_MINUS_ACC_BORROW});

	// Sequencer: capture, execute, or sleep
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_q <= ST_IDLE;
			ins_q <= '0;
			done_q <= 1'b0;
		end else if (clk_en_in) begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (instr_valid_in) begin
						ins_q <= instr_in;
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					done_q <= 1'b1;
					// sleep halts; nothing accepted until wake
					state_q <= (ins_q.op == rss_pkg::RSS_SLEEP) ? ST_SLEEP : ST_IDLE;
				end
				ST_SLEEP: begin
					if (wake_s2_q) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Accumulator writes
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			acc_q <= rss_pkg::ACC_RESET;
		end else if (clk_en_in && state_q == ST_EXEC) begin
			// literal op always lands in accumulator
			if (ins_q.op == rss_pkg::RSS_LIT_MINUS_ACC) begin
				acc_q <= result;
			end else if (ins_q.dest == rss_pkg::DEST_ACC && ins_q.op != rss_pkg::RSS_SLEEP
				&& ins_q.op != rss_pkg::RSS_NOP) begin
				acc_q <= result;
			end
		end
	end

	// Status flags
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			stat_q <= rss_pkg::STATUS_RESET;
		end else if (clk_en_in && state_q == ST_EXEC) begin
			if (ins_q.op == rss_pkg::RSS_SLEEP) begin
				// only the two power bits move
				stat_q.power_down_flag <= 1'b0;
				stat_q.watchdog_expiry_flag <= 1'b1;
			end else if (ins_q.op != rss_pkg::RSS_NOP) begin
				stat_q.carry <= c_new;
				stat_q.half_carry_flag <= dc_new;
				if (is_sub) begin
					stat_q.zero <= (result == 8'h00);
				end
			end
		end
	end

	// Watchdog counter and prescaler; tick ignored in the sleep entry cycle
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wdt_q <= rss_pkg::WDT_CLEARED;
			pre_q <= rss_pkg::PRESCALE_CLEARED;
		end else if (clk_en_in) begin
			if (state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP) begin
				wdt_q <= rss_pkg::WDT_CLEARED;
				pre_q <= rss_pkg::PRESCALE_CLEARED;
			end else if (wdt_tick_in) begin
				pre_q <= pre_q + 8'h01;
				if (pre_q == 8'hff) begin
					wdt_q <= wdt_q + 8'h01;
				end
			end
		end
	end

	// Registered outputs
	assign acc_out = acc_q;
	assign status_out = stat_q;
	assign wdt_count_out = wdt_q;
	assign prescale_out = pre_q;
	assign done_out = done_q;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sleeping_out <= 1'b0;
			osc_run_out <= 1'b1;
			busy_out <= 1'b0;
		end else if (clk_en_in) begin
			sleeping_out <= (state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP)
				|| (state_q == ST_SLEEP && !wake_s2_q);
			osc_run_out <= !((state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP)
				|| (state_q == ST_SLEEP && !wake_s2_q));
			busy_out <= (state_q == ST_IDLE && instr_valid_in) || (state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP)
				|| (state_q == ST_SLEEP && !wake_s2_q);
		end
	end

	// Assertions
	sleep_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP
		|=> !stat_q.power_down_flag && stat_q.watchdog_expiry_flag && $stable(stat_q.carry) && $stable(stat_q.zero))
		else $error("sleep status bits wrong");
	sleep_wdt_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP |=> wdt_q == 8'h00 && pre_q == 8'h00)
		else $error("watchdog not cleared on sleep");
	sleep_halt_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_SLEEP |=> sleeping_out && !osc_run_out)
		else $error("sleep did not halt");
	rot_carry_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_ROTATE_RIGHT
		|=> stat_q.carry == $past(file_rd[0]) && $stable(stat_q.zero))
		else $error("rotate carry wrong");
	dest_acc_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_REG_MINUS_ACC && ins_q.dest == rss_pkg::DEST_FILE
		|=> $stable(acc_q))
		else $error("file destination changed accumulator");
	lit_sub_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_LIT_MINUS_ACC
		|=> acc_q == 8'($past(ins_q.literal) - $past(acc_q)) && stat_q.carry == ($past(acc_q) <= $past(ins_q.literal)))
		else $error("literal subtraction wrong");
	reg_sub_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_REG_MINUS_ACC
		|=> stat_q.half_carry_flag == ($past(acc_q[3:0]) <= $past(file_rd[3:0])))
		else $error("half carry wrong");
	borrow_sub_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && ins_q.op == rss_pkg::RSS_REG_MINUS_ACC_BORROW && !stat_q.carry
		&& ins_q.dest == rss_pkg::DEST_ACC |=> acc_q == 8'($past(file_rd) - $past(acc_q) - 8'h01))
		else $error("borrow subtraction wrong");
	zero_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		clk_en_in && state_q == ST_EXEC && is_sub |=> stat_q.zero == ($past(result) == 8'h00))
		else $error("zero flag wrong");
endmodule // rss_exec

// file: test/rss_decoder_model.sv
// Decoder stand-in: offers one decoded instruction at a time to the core.
// Assumes the core takes an offer at a rising edge while busy is low.
`timescale 1ns/100ps
module rss_decoder_model (
	// Clock and core handshake
	input  wire logic              ref_clk_in,
	input  wire logic              busy_in,
	// Offer to the core
	output logic                   instr_valid_out,
	output rss_pkg::rss_instr_type instr_out
);
	int misses = 0;

	// Idle at time zero
	initial begin
		instr_valid_out = 1'b0;
		instr_out = '0;
	end

	// Offer, hold until busy shows the take, then withdraw
	task automatic issue(input rss_pkg::rss_instr_type ins, input bit take);
		int n;
		n = 0;
		@(negedge ref_clk_in);
		instr_valid_out = 1'b1;
		instr_out = ins;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (take && busy_in !== 1'b1 && n < 20);
		if (take && busy_in !== 1'b1)
			misses++;
		if (!take)
			repeat (3) @(negedge ref_clk_in);
		// Stale fields flipped so they never pass for a live offer
		instr_valid_out = 1'b0;
		instr_out = ~ins;
	endtask
endmodule // rss_decoder_model

// file: test/test_rss_exec.sv
// Bench for the execution datapath, one task per scenario.
// Assumes file registers power up at zero and only the decoder model offers instructions.
`timescale 1ns/100ps
module test_rss_exec;
	logic                    ref_clk_in = 1'b0;
	logic                    reset_in = 1'b1;
	logic                    wake_in = 1'b0;
	logic                    wdt_tick_in = 1'b0;
	logic                    clk_en_in = 1'b1;
	logic                    c_m = 1'b0;
	logic                    instr_valid_in;
	rss_pkg::rss_instr_type  instr_in;
	logic [7:0]              acc_out;
	logic [7:0]              wdt_count_out;
	logic [7:0]              prescale_out;
	rss_pkg::rss_status_type status_out;
	logic                    sleeping_out;
	logic                    osc_run_out;
	logic                    busy_out;
	logic                    done_out;
	wire [2:0]               alu_flags = {status_out.carry, status_out.half_carry_flag, status_out.zero};
	logic [7:0]              acc_m = 8'h00;
	int                      fails = 0;
	int                      num_checks = 0;

	// 100 MHz core clock
	always #5 ref_clk_in = ~ref_clk_in;

	rss_exec DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in), .wake_in(wake_in),
		.wdt_tick_in(wdt_tick_in), .acc_out(acc_out), .status_out(status_out),
		.wdt_count_out(wdt_count_out), .prescale_out(prescale_out), .sleeping_out(sleeping_out),
		.osc_run_out(osc_run_out), .busy_out(busy_out), .done_out(done_out));

	rss_decoder_model DEC (.ref_clk_in(ref_clk_in), .busy_in(busy_out),
		.instr_valid_out(instr_valid_in), .instr_out(instr_in));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One instruction, waiting a bounded time for its completion
	task automatic run(input rss_pkg::rss_op_type op, input logic dest, input logic [7:0] lit);
		int n;
		n = 0;
		DEC.issue('{op: op, addr: 7'h05, dest: dest, literal: lit}, 1'b1);
		while ((op == rss_pkg::RSS_SLEEP ? sleeping_out : done_out) !== 1'b1 && n < 10) begin
			@(negedge ref_clk_in);
			n++;
		end
		if (n == 10 || DEC.misses != 0) begin
			fails++;
			complete_run();
		end
	endtask

	task automatic t_reset();
		check({acc_out, wdt_count_out | prescale_out}, 16'h0000);
		check(status_out, rss_pkg::STATUS_RESET);
		check({sleeping_out, osc_run_out, busy_out, done_out}, 4'b0100);
		$display("reset test done");
	endtask

	// Boundaries of both compares, result zero, wrap below zero
	task automatic t_literal();
		logic [7:0] lits [8] = '{8'h00, 8'h05, 8'h05, 8'h13, 8'h12, 8'hf0, 8'hf3, 8'h10};
		logic [7:0] r;
		foreach (lits[i]) begin
			r = lits[i] - acc_m;
			run(rss_pkg::RSS_LIT_MINUS_ACC, i[0], lits[i]);
			check(acc_out, r);
			check({status_out.carry, status_out.half_carry_flag},
				{acc_m <= lits[i], acc_m[3:0] <= lits[i][3:0]});
			check(status_out.zero, r == 8'h00);
			c_m = acc_m <= lits[i];
			acc_m = r;
		end
		$display("literal test done");
	endtask

	// File register 5 starts at its power-up zero; carry model from the literal test
	task automatic t_file();
		logic [8:0] d;
		logic [4:0] h;
		logic [7:0] f;
		logic [7:0] r;
		logic       c;
		logic [1:0] keep;
		f = rss_pkg::FILE_RESET;
		c = c_m;
		keep = {status_out.half_carry_flag, status_out.zero};
		// into the file: old carry to bit 7, bit 0 to carry
		run(rss_pkg::RSS_ROTATE_RIGHT, rss_pkg::DEST_FILE, 8'h00);
		{f, c} = {c, f};
		check(alu_flags, {c, keep});
		check(acc_out, acc_m);
		// carry now clear, so the borrow takes one more off
		run(rss_pkg::RSS_REG_MINUS_ACC_BORROW, rss_pkg::DEST_ACC, 8'h00);
		d = {1'b0, f} - {1'b0, acc_m} - {8'h00, !c};
		h = {1'b0, f[3:0]} - {1'b0, acc_m[3:0]} - {4'h0, !c};
		check(acc_out, d[7:0]);
		check(alu_flags, {!d[8], !h[4], d[7:0] == 8'h00});
		acc_m = d[7:0];
		c = !d[8];
		// back into the file, accumulator left alone
		run(rss_pkg::RSS_REG_MINUS_ACC, rss_pkg::DEST_FILE, 8'h00);
		r = f - acc_m;
		check(alu_flags, {acc_m <= f, acc_m[3:0] <= f[3:0], r == 8'h00});
		check(acc_out, acc_m);
		c = acc_m <= f;
		f = r;
		// rotate the new file value into the accumulator
		run(rss_pkg::RSS_ROTATE_RIGHT, rss_pkg::DEST_ACC, 8'h00);
		{acc_m, c} = {c, f};
		check({acc_out, 7'h00, status_out.carry}, {acc_m, 7'h00, c});
		// Known flags again before sleep
		run(rss_pkg::RSS_LIT_MINUS_ACC, 1'b0, 8'h40);
		acc_m = 8'h40 - acc_m;
		check(acc_out, acc_m);
		$display("file test done");
	endtask

	// Enable low: an offer and watchdog ticks must leave every register alone
	task automatic t_freeze();
		@(negedge ref_clk_in);
		clk_en_in = 1'b0;
		wdt_tick_in = 1'b1;
		DEC.issue('{op: rss_pkg::RSS_LIT_MINUS_ACC, addr: 7'h05, dest: 1'b0, literal: 8'h77}, 1'b0);
		clk_en_in = 1'b1;
		wdt_tick_in = 1'b0;
		check({acc_out, 6'h00, busy_out, done_out}, {acc_m, 8'h00});
		check({wdt_count_out, prescale_out}, 16'h0000);
		$display("freeze test done");
	endtask

	task automatic t_sleep();
		logic [2:0] flags;
		int n;
		wdt_tick_in = 1'b1;
		repeat (300) @(negedge ref_clk_in);
		wdt_tick_in = 1'b0;
		check({wdt_count_out, prescale_out}, 16'h012c);
		flags = {status_out.carry, status_out.half_carry_flag, status_out.zero};
		run(rss_pkg::RSS_SLEEP, 1'b0, 8'h00);
		check({wdt_count_out, prescale_out}, 16'h0000);
		check(status_out, {flags, 2'b01});
		check({sleeping_out, osc_run_out}, 2'b10);
		// Offer while asleep must be ignored
		DEC.issue('{op: rss_pkg::RSS_LIT_MINUS_ACC, addr: 7'h00, dest: 1'b0, literal: 8'h99}, 1'b0);
		check({acc_out, 7'h00, sleeping_out}, {acc_m, 8'h01});
		wake_in = 1'b1;
		n = 0;
		while (sleeping_out !== 1'b0 && n < 10) begin
			@(negedge ref_clk_in);
			n++;
		end
		wake_in = 1'b0;
		if (n == 10) begin
			fails++;
			complete_run();
		end
		check({sleeping_out, osc_run_out}, 2'b01);
		run(rss_pkg::RSS_LIT_MINUS_ACC, 1'b0, 8'h99);
		check(acc_out, 8'(8'h99 - acc_m));
		$display("sleep test done");
	endtask

	// Main sequence
	initial begin
		repeat (20) @(negedge ref_clk_in);
		reset_in = 1'b0;
		t_reset();
		t_literal();
		t_file();
		t_freeze();
		t_sleep();
		complete_run();
	end
endmodule // test_rss_exec
